//--- include/perf_request_params.svh
// Addresses, field positions, masks and timing for the hint resolver
`ifndef PERF_REQUEST_PARAMS_SVH
`define PERF_REQUEST_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define THREAD_REQ_ADDR 32'h0000_0774
`define PKG_REQ_ADDR 32'h0000_0772
`define OVR_INFO_ADDR 32'h0000_0775
`define POLARITY_ADDR 32'h0000_0776
`define STATUS_ADDR 32'h0000_0777
`define THERM_ADDR 32'h0000_0778

// ----------------------------------------------------------------
// Hint fields of thread and package registers; override holds min, max, energy only
// ----------------------------------------------------------------
`define F_MIN 7:0
`define F_MAX 15:8
`define F_DES 23:16
`define F_EPP 31:24
`define F_WIN 41:32
`define B_PKGSEL 42
`define V_WIN 59
`define V_EPP 60
`define V_DES 61
`define V_MAX 62
`define V_MIN 63
`define O_EPP 60
`define O_MAX 62
`define O_MIN 63
`define B_INVERT 0

// ----------------------------------------------------------------
// Writable and readable masks, reset values
// ----------------------------------------------------------------
`define THREAD_MASK 64'hf800_07ff_ffff_ffff
`define PKG_MASK 64'h0000_03ff_ffff_ffff
`define OVR_MASK 64'hd000_0000_ff00_ffff
`define STATUS_MASK 64'h0000_0000_0000_003d
`define THREAD_RST 64'h0000_0000_8000_ff00
`define PKG_RST 64'h0000_0000_8000_ff00
`define OVR_RST 64'h0000_0000_0000_0000
`define INVERT_RST 1'b0

// ----------------------------------------------------------------
// Event status and thermal bits
// ----------------------------------------------------------------
`define ST_GUAR 0
`define ST_MIN 2
`define ST_HIGH 3
`define ST_ENTRY 4
`define ST_EXIT 5
`define TH_CUR 12
`define TH_CUR_LOG 13
`define TH_XDOM 14
`define TH_XDOM_LOG 15
`define EV_GUAR 0
`define EV_MIN 1
`define EV_HIGH 2
`define EV_ENTRY 3
`define EV_EXIT 4
`define EV_COUNT 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_HZ 20000000
`define PACE_MS 1000
`define PACE_CYCLES ((`CLOCK_HZ / 1000) * `PACE_MS)

`endif

//--- include/perf_pkg.sv
// Types shared by the hint resolver files
package perf_pkg;
  typedef struct packed {
    logic [7:0] min_level;
    logic [7:0] max_level;
    logic [7:0] desired;
    logic [7:0] energy_pref;
    logic [9:0] window;
  } hints_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } reg_access_t;
endpackage

//--- core/event_pacer.sv
// Per-event hold-off so each event kind passes at most once per period
`timescale 1ns/1ps
`default_nettype none
module event_pacer #(
  parameter int unsigned N = 5,
  parameter int unsigned HOLD = 20000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] ev,
  output logic [N-1:0] pass
);
  logic [31:0] cnt [N];

  always_comb begin
    for (int i = 0; i < N; i++) begin
      pass[i] = ev[i] && (cnt[i] == 32'h0);
    end
  end

  // Counter loads on a passed event, blocking repeats until it expires
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (rst) begin
        cnt[i] <= 32'h0;
      end else if (pass[i]) begin
        cnt[i] <= 32'(HOLD - 1);
      end else if (cnt[i] != 32'h0) begin
        cnt[i] <= cnt[i] - 32'h1;
      end
    end
  end
endmodule // event_pacer
`default_nettype wire

//--- core/perf_request_resolution.sv
// Performance hint resolver with its request, override and status registers
//
// Overview of operation
// - Package request holds hint fields only, no select or valid bits.
// - Package values apply unless the thread package-select says otherwise.
// - Single performance-state mode offered only without package register.
// - Controller values beat package values for min, max and energy pref.
// - Override register written only by controller; software writes ignored.
// - Override: min 7:0, max 15:8, energy 31:24; 23:16, 59:32 zero.
// - Override flags: energy bit 60, max bit 62, min bit 63.
// - Desired and window: package value if selected and valid clear.
// - Min, max, energy: controller, else package, else thread value.
// - Polarity clear: select zero means no hints from package register.
// - Polarity set: meaning of package-select is inverted.
// - Polarity bit resets to zero.
// - Polarity access with global enable clear faults instead.
// - Status bits 0, 2, 3 set on events; bit 1 reads zero.
// - Status bit 4 on override start, bit 5 on override stop.
// - Status bits stay set until software writes zero.
// - Normal wake-up excursions below minimum set no status bit.
// - Each event kind reported at most once per second.
// - Thermal bit 12 current limit live, bit 13 sticky log.
// - Thermal bit 14 cross-domain limit live, bit 15 sticky log.
// - Thread fields: min, max, desired, energy, window at fixed bits.
// - Thread valid bits 63:59, package-select bit 42.
`timescale 1ns/1ps
`default_nettype none
`include "perf_request_params.svh"
module perf_request_resolution import perf_pkg::*; #(
  parameter int unsigned PACE_CYCLES = `PACE_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register access from the core
  input wire reg_access_t ACCESS,
  output logic ACCESS_DONE,
  output logic ACCESS_FAULT,
  output logic [63:0] READ_DATA,
  // Global hint enable from the power management register
  input wire logic PERF_HINT_ENABLE,
  // Sideband management link writes
  input wire logic CTL_WR,
  input wire logic [63:0] CTL_DATA,
  // Hardware events and limit levels
  input wire logic GUAR_CHANGE,
  input wire logic HIGHEST_CHANGE,
  input wire logic MIN_LEVEL_MISSED,
  input wire logic WAKE_EXCURSION,
  input wire logic CURRENT_LIMIT,
  input wire logic CROSS_LIMIT,
  // Resolved hints
  output hints_t RESOLVED,
  output logic SINGLE_PSTATE_MODE
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [63:0] thread_req;
  logic [63:0] pkg_req;
  logic [63:0] ovr_info;
  logic [63:0] status;
  logic [63:0] therm;
  logic invert;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic acc = ACCESS.req;
  wire logic hit_thr = ACCESS.addr == `THREAD_REQ_ADDR;
  wire logic hit_pkg = ACCESS.addr == `PKG_REQ_ADDR;
  wire logic hit_ovr = ACCESS.addr == `OVR_INFO_ADDR;
  wire logic hit_pol = ACCESS.addr == `POLARITY_ADDR;
  wire logic hit_sts = ACCESS.addr == `STATUS_ADDR;
  wire logic hit_thm = ACCESS.addr == `THERM_ADDR;
  wire logic mapped = hit_thr | hit_pkg | hit_ovr | hit_pol | hit_sts
                      | hit_thm;
  wire logic pol_blocked = hit_pol && !PERF_HINT_ENABLE;
  wire logic fault = acc && (!mapped || pol_blocked);
  wire logic wr_ok = acc && ACCESS.wr && !fault;
  wire logic rd_ok = acc && !ACCESS.wr && !fault;
  wire logic sts_wr = wr_ok && hit_sts;
  wire logic thm_wr = wr_ok && hit_thm;

  // ----------------------------------------------------------------
  // Software request registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      thread_req <= `THREAD_RST;
      pkg_req <= `PKG_RST;
      invert <= `INVERT_RST;
    end else if (wr_ok) begin
      if (hit_thr) begin
        thread_req <= ACCESS.wdata & `THREAD_MASK;
      end
      if (hit_pkg) begin
        pkg_req <= ACCESS.wdata & `PKG_MASK;
      end
      if (hit_pol) begin
        invert <= ACCESS.wdata[`B_INVERT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Controller override register
  // ----------------------------------------------------------------
  // Only the sideband port reaches it; software writes fall away
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ovr_info <= `OVR_RST;
    end else if (CTL_WR) begin
      ovr_info <= CTL_DATA & `OVR_MASK;
    end
  end

  wire logic [2:0] forced_old = {ovr_info[`O_MIN], ovr_info[`O_MAX],
                                 ovr_info[`O_EPP]};
  wire logic [2:0] forced_new = {CTL_DATA[`O_MIN], CTL_DATA[`O_MAX],
                                 CTL_DATA[`O_EPP]};
  wire logic began = CTL_WR && |(forced_new & ~forced_old);
  wire logic ended = CTL_WR && |(forced_old & ~forced_new);

  // ----------------------------------------------------------------
  // Event pacing and status
  // ----------------------------------------------------------------
  logic [`EV_COUNT-1:0] ev_raw;
  logic [`EV_COUNT-1:0] ev_pass;
  logic [63:0] status_set;
  logic [63:0] next_status;

  always_comb begin
    ev_raw = '0;
    ev_raw[`EV_GUAR] = GUAR_CHANGE;
    ev_raw[`EV_MIN] = MIN_LEVEL_MISSED && !WAKE_EXCURSION;
    ev_raw[`EV_HIGH] = HIGHEST_CHANGE;
    ev_raw[`EV_ENTRY] = began;
    ev_raw[`EV_EXIT] = ended;
  end

  event_pacer #(
    .N(`EV_COUNT),
    .HOLD(PACE_CYCLES)
  ) pacer (
    .clk(CLOCK),
    .rst(RST),
    .ev(ev_raw),
    .pass(ev_pass)
  );

  always_comb begin
    status_set = '0;
    status_set[`ST_GUAR] = ev_pass[`EV_GUAR];
    status_set[`ST_MIN] = ev_pass[`EV_MIN];
    status_set[`ST_HIGH] = ev_pass[`EV_HIGH];
    status_set[`ST_ENTRY] = ev_pass[`EV_ENTRY];
    status_set[`ST_EXIT] = ev_pass[`EV_EXIT];
  end

  // Writing zero clears; a set in the same cycle wins
  assign next_status = ((status & (sts_wr ? ACCESS.wdata : '1))
                        | status_set) & `STATUS_MASK;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // Thermal limit bits
  // ----------------------------------------------------------------
  wire logic keep_cur = !thm_wr || ACCESS.wdata[`TH_CUR_LOG];
  wire logic keep_xdom = !thm_wr || ACCESS.wdata[`TH_XDOM_LOG];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      therm <= '0;
    end else begin
      therm[`TH_CUR] <= CURRENT_LIMIT;
      therm[`TH_CUR_LOG] <= (therm[`TH_CUR_LOG] && keep_cur)
                            || CURRENT_LIMIT;
      therm[`TH_XDOM] <= CROSS_LIMIT;
      therm[`TH_XDOM_LOG] <= (therm[`TH_XDOM_LOG] && keep_xdom)
                             || CROSS_LIMIT;
    end
  end

  // ----------------------------------------------------------------
  // Hint resolution
  // ----------------------------------------------------------------
  function automatic logic [9:0] pick(input logic forced,
                                      input logic [9:0] ctl,
                                      input logic [9:0] pkg,
                                      input logic [9:0] thr,
                                      input logic use_pkg);
    logic [9:0] val;
    if (forced) begin
      val = ctl;
    end else if (use_pkg) begin
      val = pkg;
    end else begin
      val = thr;
    end
    return val;
  endfunction

  // Polarity flips which select value enables package sourcing
  wire logic pkg_mode = thread_req[`B_PKGSEL] ^ invert;
  wire logic pkg_min = pkg_mode && !thread_req[`V_MIN];
  wire logic pkg_max = pkg_mode && !thread_req[`V_MAX];
  wire logic pkg_des = pkg_mode && !thread_req[`V_DES];
  wire logic pkg_epp = pkg_mode && !thread_req[`V_EPP];
  wire logic pkg_win = pkg_mode && !thread_req[`V_WIN];

  hints_t next_res;

  always_comb begin
    next_res.min_level = 8'(pick(ovr_info[`O_MIN],
      10'(ovr_info[`F_MIN]), 10'(pkg_req[`F_MIN]),
      10'(thread_req[`F_MIN]), pkg_min));
    next_res.max_level = 8'(pick(ovr_info[`O_MAX],
      10'(ovr_info[`F_MAX]), 10'(pkg_req[`F_MAX]),
      10'(thread_req[`F_MAX]), pkg_max));
    next_res.energy_pref = 8'(pick(ovr_info[`O_EPP],
      10'(ovr_info[`F_EPP]), 10'(pkg_req[`F_EPP]),
      10'(thread_req[`F_EPP]), pkg_epp));
    next_res.desired = 8'(pick(1'b0, 10'h0, 10'(pkg_req[`F_DES]),
      10'(thread_req[`F_DES]), pkg_des));
    next_res.window = pick(1'b0, 10'h0, pkg_req[`F_WIN],
      thread_req[`F_WIN], pkg_win);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RESOLVED <= '0;
      SINGLE_PSTATE_MODE <= 1'b0;
    end else begin
      RESOLVED <= next_res;
      // Package register exists here, so single mode stays off
      SINGLE_PSTATE_MODE <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path and access answer
  // ----------------------------------------------------------------
  logic [63:0] rd_mux;

  always_comb begin
    if (hit_thr) begin
      rd_mux = thread_req;
    end else if (hit_pkg) begin
      rd_mux = pkg_req;
    end else if (hit_ovr) begin
      rd_mux = ovr_info;
    end else if (hit_pol) begin
      rd_mux = {63'h0, invert};
    end else if (hit_sts) begin
      rd_mux = status;
    end else if (hit_thm) begin
      rd_mux = therm;
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ACCESS_DONE <= 1'b0;
      ACCESS_FAULT <= 1'b0;
      READ_DATA <= '0;
    end else begin
      ACCESS_DONE <= acc && !fault;
      ACCESS_FAULT <= fault;
      READ_DATA <= rd_ok ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_thread_only: assert property (@(posedge CLOCK) disable iff (RST)
    !pkg_mode |=> RESOLVED.desired == $past(thread_req[`F_DES]))
    else $error("desired not taken from thread register");

  a_force_wins: assert property (@(posedge CLOCK) disable iff (RST)
    ovr_info[`O_MIN] |=> RESOLVED.min_level == $past(ovr_info[`F_MIN]))
    else $error("forced minimum not applied");

  a_pkg_window: assert property (@(posedge CLOCK) disable iff (RST)
    pkg_mode && !thread_req[`V_WIN]
    |=> RESOLVED.window == $past(pkg_req[`F_WIN]))
    else $error("package window not applied");

  a_ovr_readonly: assert property (@(posedge CLOCK) disable iff (RST)
    acc && ACCESS.wr && hit_ovr && !CTL_WR |=> $stable(ovr_info))
    else $error("software changed override register");

  a_ovr_reserved: assert property (@(posedge CLOCK) disable iff (RST)
    (ovr_info & ~`OVR_MASK) == 64'h0)
    else $error("override reserved bits set");

  a_polarity_reset: assert property (@(posedge CLOCK)
    RST |=> !invert)
    else $error("polarity not cleared by reset");

  a_gp_disabled: assert property (@(posedge CLOCK) disable iff (RST)
    acc && hit_pol && !PERF_HINT_ENABLE |=> ACCESS_FAULT && !ACCESS_DONE)
    else $error("polarity access without enable did not fault");

  a_status_sticky: assert property (@(posedge CLOCK) disable iff (RST)
    status[`ST_GUAR] && !sts_wr |=> status[`ST_GUAR])
    else $error("status bit dropped without clear");

  a_entry_sets: assert property (@(posedge CLOCK) disable iff (RST)
    ev_pass[`EV_ENTRY] |=> status[`ST_ENTRY])
    else $error("override entry not recorded");

  a_current_log: assert property (@(posedge CLOCK) disable iff (RST)
    CURRENT_LIMIT |=> therm[`TH_CUR] && therm[`TH_CUR_LOG])
    else $error("current limit not logged");

  a_xdom_log: assert property (@(posedge CLOCK) disable iff (RST)
    CROSS_LIMIT |=> therm[`TH_XDOM] && therm[`TH_XDOM_LOG])
    else $error("cross-domain limit not logged");

  a_exit_sets: assert property (@(posedge CLOCK) disable iff (RST)
    ev_pass[`EV_EXIT] |=> status[`ST_EXIT])
    else $error("override exit not recorded");

  a_status_spare: assert property (@(posedge CLOCK) disable iff (RST)
    (status & ~`STATUS_MASK) == 64'h0)
    else $error("reserved status bit set");

  a_wake_quiet: assert property (@(posedge CLOCK) disable iff (RST)
    WAKE_EXCURSION |-> !status_set[`ST_MIN])
    else $error("normal excursion reported");

  a_pace_hold: assert property (@(posedge CLOCK) disable iff (RST)
    ev_pass[`EV_HIGH] |=> !ev_pass[`EV_HIGH])
    else $error("event passed twice in a row");

  a_invert_select: assert property (@(posedge CLOCK) disable iff (RST)
    invert && thread_req[`B_PKGSEL]
    |=> RESOLVED.window == $past(thread_req[`F_WIN]))
    else $error("inverted select did not use thread register");

  a_single_off: assert property (@(posedge CLOCK) disable iff (RST)
    !SINGLE_PSTATE_MODE)
    else $error("single state mode offered with package register");
endmodule // perf_request_resolution
`default_nettype wire

//--- sim/mgmt_ctl_model.sv
// Management controller stand-in that drives the sideband override writes
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctl_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests from the bench
  input wire logic go,
  input wire logic [63:0] value,
  // Sideband link
  output logic ctl_wr,
  output logic [63:0] ctl_data
);
  // ------------------------------------------------------------
  // Write launch
  // ------------------------------------------------------------
  // Data is scrambled between writes so a stale word never looks held
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_wr <= 1'b0;
      ctl_data <= 64'h0;
    end else begin
      ctl_wr <= go;
      ctl_data <= go ? value : ~ctl_data;
    end
  end
endmodule // mgmt_ctl_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the performance hint resolver
`timescale 1ns/1ps
`default_nettype none
`include "perf_request_params.svh"
module testbench import perf_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  reg_access_t access = '0;
  logic enable = 1'b1;
  logic go = 1'b0;
  logic [63:0] gval = 64'h0;
  logic [2:0] ev = 3'b000;
  logic wake = 1'b0;
  logic [1:0] lim = 2'b00;
  logic ctl_wr, done, fault, single;
  logic [63:0] ctl_data, rdata, rd, d;
  hints_t res;
  logic [63:0] thr, pkg, ovr, pol;
  int err_count = 0;
  int checks_done = 0;
  int seed = 33;
  int i, k;
  int sbit [3] = '{0, 3, 2};

  mgmt_ctl_model u_mgmt_ctl_model (.clock(clock), .rst(rst), .go(go),
    .value(gval), .ctl_wr(ctl_wr), .ctl_data(ctl_data));

  perf_request_resolution #(.PACE_CYCLES(16)) u_perf_request_resolution (
    .CLOCK(clock), .RST(rst), .ACCESS(access), .ACCESS_DONE(done),
    .ACCESS_FAULT(fault), .READ_DATA(rdata), .PERF_HINT_ENABLE(enable),
    .CTL_WR(ctl_wr), .CTL_DATA(ctl_data), .GUAR_CHANGE(ev[0]),
    .HIGHEST_CHANGE(ev[1]), .MIN_LEVEL_MISSED(ev[2]),
    .WAKE_EXCURSION(wake), .CURRENT_LIMIT(lim[0]), .CROSS_LIMIT(lim[1]),
    .RESOLVED(res), .SINGLE_PSTATE_MODE(single));

  initial begin
    forever #25 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------
  function automatic hints_t fld(input logic [63:0] r);
    return {r[`F_MIN], r[`F_MAX], r[`F_DES], r[`F_EPP], r[`F_WIN]};
  endfunction

  function automatic hints_t expect_hints();
    hints_t t, p, o, h;
    logic sel;
    t = fld(thr);
    p = fld(pkg);
    o = fld(ovr);
    sel = thr[`B_PKGSEL] ^ pol[`B_INVERT];
    h.min_level = ovr[`O_MIN] ? o.min_level :
      (sel & ~thr[`V_MIN]) ? p.min_level : t.min_level;
    h.max_level = ovr[`O_MAX] ? o.max_level :
      (sel & ~thr[`V_MAX]) ? p.max_level : t.max_level;
    h.energy_pref = ovr[`O_EPP] ? o.energy_pref :
      (sel & ~thr[`V_EPP]) ? p.energy_pref : t.energy_pref;
    h.desired = (sel & ~thr[`V_DES]) ? p.desired : t.desired;
    h.window = (sel & ~thr[`V_WIN]) ? p.window : t.window;
    return h;
  endfunction

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chkh();
    chk({22'h0, res}, {22'h0, expect_hints()});
  endtask

  task results();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task acc(input logic wr, input logic [31:0] a, input logic [63:0] dv,
           input logic flt);
    @(posedge clock);
    access <= '{req: 1'b1, wr: wr, addr: a, wdata: dv};
    @(posedge clock);
    access.req <= 1'b0;
    #1;
    chk({62'h0, done, fault}, {62'h0, ~flt, flt});
    rd = rdata;
  endtask

  task rdchk(input logic [31:0] a, input logic [63:0] e);
    acc(1'b0, a, 64'h0, 1'b0);
    chk(rd, e);
  endtask

  // Resolved hints settle one cycle after the write completes
  task wreg(input logic [31:0] a, input logic [63:0] dv);
    acc(1'b1, a, dv, 1'b0);
    @(posedge clock);
    #1;
    chkh();
  endtask

  task ctl(input logic [63:0] v);
    @(posedge clock);
    go <= 1'b1;
    gval <= v;
    @(posedge clock);
    go <= 1'b0;
    ovr = v & `OVR_MASK;
    repeat (2) @(posedge clock);
    #1;
    chkh();
  endtask

  task pulse(input int n);
    @(posedge clock);
    ev[n] <= 1'b1;
    @(posedge clock);
    ev[n] <= 1'b0;
    @(posedge clock);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    thr = `THREAD_RST;
    pkg = `PKG_RST;
    ovr = 64'h0;
    pol = 64'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chkh();
    chk({63'h0, single}, 64'h0);
    rdchk(`THREAD_REQ_ADDR, `THREAD_RST);
    rdchk(`PKG_REQ_ADDR, `PKG_RST);
    rdchk(`POLARITY_ADDR, 64'h0);
    rdchk(`OVR_INFO_ADDR, 64'h0);
    for (i = 0; i < 40; i++) begin
      d = {$random(seed), $random(seed)};
      thr = d & `THREAD_MASK;
      wreg(`THREAD_REQ_ADDR, d);
      d = {$random(seed), $random(seed)};
      pkg = d & `PKG_MASK;
      wreg(`PKG_REQ_ADDR, d);
      d = {$random(seed), $random(seed)};
      pol = d & 64'h1;
      wreg(`POLARITY_ADDR, d);
      ctl({$random(seed), $random(seed)});
      rdchk(`OVR_INFO_ADDR, ovr);
      rdchk(`THREAD_REQ_ADDR, thr);
      rdchk(`PKG_REQ_ADDR, pkg);
    end
    acc(1'b1, `OVR_INFO_ADDR, ~ovr, 1'b0);
    rdchk(`OVR_INFO_ADDR, ovr);
    @(posedge clock);
    enable <= 1'b0;
    acc(1'b1, `POLARITY_ADDR, ~pol, 1'b1);
    acc(1'b0, `POLARITY_ADDR, 64'h0, 1'b1);
    @(posedge clock);
    enable <= 1'b1;
    rdchk(`POLARITY_ADDR, pol);
    acc(1'b0, 32'h0000_0780, 64'h0, 1'b1);
    // Override entry and exit, each after the pacer has lapsed
    ctl(64'h0);
    repeat (20) @(posedge clock);
    acc(1'b1, `STATUS_ADDR, 64'h0, 1'b0);
    ctl(64'h8000_0000_0000_0000);
    rdchk(`STATUS_ADDR, 64'h10);
    acc(1'b1, `STATUS_ADDR, 64'h0, 1'b0);
    repeat (20) @(posedge clock);
    ctl(64'h0);
    rdchk(`STATUS_ADDR, 64'h20);
    acc(1'b1, `STATUS_ADDR, 64'h0, 1'b0);
    @(posedge clock);
    wake <= 1'b1;
    pulse(2);
    rdchk(`STATUS_ADDR, 64'h0);
    @(posedge clock);
    wake <= 1'b0;
    repeat (20) @(posedge clock);
    for (k = 0; k < 3; k++) begin
      pulse(k);
      acc(1'b1, `STATUS_ADDR, {64{1'b1}}, 1'b0);
      rdchk(`STATUS_ADDR, 64'h1 << sbit[k]);
      acc(1'b1, `STATUS_ADDR, 64'h0, 1'b0);
      pulse(k);
      rdchk(`STATUS_ADDR, 64'h0);
      repeat (20) @(posedge clock);
      pulse(k);
      rdchk(`STATUS_ADDR, 64'h1 << sbit[k]);
      acc(1'b1, `STATUS_ADDR, 64'h0, 1'b0);
    end
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      lim <= 2'b01 << k;
      repeat (2) @(posedge clock);
      rdchk(`THERM_ADDR, 64'h3000 << (2 * k));
      @(posedge clock);
      lim <= 2'b00;
      repeat (2) @(posedge clock);
      rdchk(`THERM_ADDR, 64'h2000 << (2 * k));
      acc(1'b1, `THERM_ADDR, 64'h0, 1'b0);
      rdchk(`THERM_ADDR, 64'h0);
    end
    results();
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge clock);
    err_count++;
    results();
  end
endmodule // testbench
`default_nettype wire
